// [bench/pss_checker.sv]
// Port assertions for the standby power sequencer.
`timescale 1ns/1ps
`default_nettype none
module pss_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [1:0] d1_level,
   input wire logic gating_trigger,
   input wire logic [15:0] active_step_value
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [7:0] gap;
   logic [15:0] last;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap <= 8'h00;
         last <= 16'h0000;
      end else begin
         last <= active_step_value;
         if (active_step_value != last) begin
            gap <= 8'h00;
         end else if (gap != 8'hFF) begin
            gap <= gap + 8'h01;
         end
      end
   end
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   pready_access_a: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
      else $error("read data outside read answer");
   gate_pulse_a: assert property (
      gating_trigger |=> !gating_trigger)
      else $error("gating trigger longer than one cycle");
   skip_zero_a: assert property (
      $changed(active_step_value) |-> active_step_value != 16'h0000)
      else $error("disabled step copied");
   div_wait_a: assert property (
      $changed(active_step_value) && $past(active_step_value[12])
      |-> gap >= 8'h40)
      else $error("copy too soon after divide step");
   level_wait_a: assert property (
      $changed(active_step_value) && $past(active_step_value[11])
      |-> $past(d1_level[1], 2))
      else $error("advanced before second level");
   sel_hold_a: assert property (
      $changed(active_step_value) && active_step_value[11:8] != 4'h0
      |=> $stable(active_step_value))
      else $error("advanced on fresh comparator");
   cover property (gating_trigger);
   cover property (pslverr);
   cover property ($changed(active_step_value) && $past(active_step_value[12]));
endmodule // pss_checker
bind pss_sequencer pss_checker u_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .prdata, .pready, .pslverr, .d1_level, .gating_trigger,
   .active_step_value);
`default_nettype wire

// [bench/tb_top.sv]
// Random and directed tests of the standby power sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, ulp;
   logic gating_ack, gating_trigger;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [1:0] main_level, d1_level;
   logic [3:0] wakeup_event;
   logic [15:0] active_step_value, active_main_cfg, active_d1_cfg;
   logic [15:0] s1, s3, c3, prev;
   logic [15:0] bv [6] = '{16'hC0E3, 16'h88DB, 16'h80EB, 16'h80F3,
      16'h0000, 16'h0000};
   logic [15:0] hist [$];
   int mismatches, n_compared, n_gate, n;
   pss_sequencer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .main_level, .d1_level,
      .wakeup_event, .gating_ack, .gating_trigger, .active_step_value,
      .active_main_cfg, .active_d1_cfg);
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      n_compared++;
      if (s !== x) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   // Entry step 2 value depends on whether the low-power regulator is used.
   function automatic logic [15:0] entry_step2(input logic u);
      return u ? 16'hE0E3 : 16'hE0E4;
   endfunction
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic prog(input int s, input int y, input logic [15:0] v, m, d);
      apb(1'b1, 12'(256 + s + 4 * y), {16'h0000, v});
      apb(1'b1, 12'(280 + s + 4 * y), {16'h0000, m});
      apb(1'b1, 12'(304 + s + 4 * y), {16'h0000, d});
   endtask
   task automatic idle(input int b);
      int k;
      k = 0;
      do begin
         apb(1'b0, 12'h000, 32'h0);
         k++;
      end while (r[b] !== 1'b0 && k < 400);
      chk(r[b], 1'b0);
      do begin
         apb(1'b0, 12'h004, 32'h0);
         k++;
      end while (r[2:0] !== 3'h0 && k < 800);
      chk(r[2:0], 3'h0);
   endtask
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      if (gating_trigger === 1'b1) n_gate++;
      if (active_step_value !== prev) hist.push_back(active_step_value);
      prev = active_step_value;
   end
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      #200000;
      mismatches++;
      wrap_up();
   end
   initial begin
      {psel, penable, pwrite, gating_ack, presetn} = 5'h00;
      {paddr, pwdata, main_level, d1_level, wakeup_event} = 52'h0;
      prev = 16'h0000;
      r = $urandom(32'hef22b087);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(active_main_cfg, 32'h0);
      apb(1'b0, 12'h200, 32'h0);
      chk(e, 32'h1);
      ulp = 1'($urandom_range(1, 0));
      for (int y = 0; y < 6; y++)
         prog(0, y, y == 0 ? 16'h80FB : y == 1 ? entry_step2(ulp)
            : 16'h0, y < 2 ? 16'h0504 : 16'($urandom), 16'h0504);
      apb(1'b0, 12'h100, 32'h0);
      chk(r, 32'h80FB);
      hist.delete();
      apb(1'b1, 12'h000, 32'h111);
      idle(2);
      chk(hist.size(), 2);
      chk(hist[0], 16'h80FB);
      chk(hist[1], entry_step2(ulp));
      chk(active_main_cfg, 16'h0504);
      chk(n_gate, 0);
      for (int y = 0; y < 6; y++)
         prog(72, y, bv[y], y == 3 ? 16'h2544 : 16'h0504,
            y == 3 ? 16'h2544 : 16'h0504);
      apb(1'b1, 12'h000, 32'h010);
      hist.delete();
      wakeup_event <= 4'h1;
      repeat (8) @(posedge pclk);
      wakeup_event <= 4'h0;
      repeat (60) @(posedge pclk);
      chk(active_step_value, 16'h88DB);
      d1_level <= 2'h2;
      n = 0;
      while (n_gate == 0 && n < 400) begin
         @(posedge pclk);
         n++;
      end
      @(posedge pclk);
      chk(hist.size(), 4);
      for (int k = 0; k < 4; k++) chk(hist[k], bv[k]);
      chk(active_main_cfg, 16'h2544);
      chk(active_d1_cfg, 16'h2544);
      chk(n_gate, 1);
      gating_ack <= 1'b1;
      idle(3);
      gating_ack <= 1'b0;
      for (int k = 0; k < 3; k++) begin
         s1 = 16'($urandom) & 16'hE0FF | 16'h1000;
         s3 = 16'($urandom) & 16'hE0FF | 16'h0001;
         c3 = 16'($urandom);
         for (int y = 0; y < 6; y++)
            prog(0, y, y == 0 ? s1 : y == 2 ? s3 : 16'h0,
               y == 2 ? c3 : 16'($urandom), y == 2 ? c3 : 16'($urandom));
         hist.delete();
         apb(1'b1, 12'h000, 32'h101);
         idle(2);
         chk(hist.size(), 2);
         chk(hist[1], s3);
         chk(active_main_cfg, c3);
         chk(active_d1_cfg, c3);
      end
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire

// [core/pss_consts.vh]
// Constants for the standby power sequencer: offsets, fields and counts.
`ifndef PSS_CONSTS_VH
`define PSS_CONSTS_VH
`define PSS_OFF_CONTROL 12'h000
`define PSS_OFF_STATUS 12'h004
`define PSS_OFF_ACT_STEP 12'h008
`define PSS_OFF_ACT_MAIN 12'h00C
`define PSS_OFF_ACT_D1 12'h010
`define PSS_OFF_STEP_BASE 12'h100
`define PSS_STEP_WORDS 36
`define PSS_STEPS 6
`define PSS_CTL_TRIG_A 0
`define PSS_CTL_TRIG_B 1
`define PSS_CTL_EN_A 2
`define PSS_CTL_EN_B 3
`define PSS_CTL_WAKE_LSB 4
`define PSS_CTL_BYPASS 8
`define PSS_STEP_DIV_BIT 12
`define PSS_STEP_SEL_MSB 11
`define PSS_STEP_SEL_LSB 8
`define PSS_CFG_CMP_EN_BIT 2
`define PSS_CFG_TRIG_EN_BIT 13
`define PSS_DIV_WAIT_CYCLES 7'h40
`define PSS_STEP_DISABLED 16'h0000
`define PSS_SEL_NONE 4'h0
`endif

// [core/pss_delay.v]
// Countdown that holds the next step copy after a clock-divide copy.
`timescale 1ns/1ps
`default_nettype none
`include "pss_consts.vh"
module pss_delay (
   input wire pclk,
   input wire presetn,
   input wire start,
   output wire done
);
   reg [6:0] count;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 7'h00;
      end else if (start) begin
         count <= `PSS_DIV_WAIT_CYCLES;
      end else if (count != 7'h00) begin
         count <= count - 7'h01;
      end
   end

   assign done = (count == 7'h00) && !start;
endmodule // pss_delay
`default_nettype wire

// [core/pss_sequencer.v]
// Standby power sequencer with APB step registers and two sequences.
//
// Operation
// - Entry step 1 (80FBh, 0504h): triggers and domain clock off.
// - Entry step 2 (E0E3h or E0E4h): domain regulator, comparators off.
// - A step value of 0000h is skipped without copying anything.
// - Wake step 1 (C0E3h): main regulator 011, comparator on, no triggers.
// - Wakeup step 2 waits for the second domain-one level before step 3.
// - A freshly enabled comparator reports level not reached.
// - Wakeup step 4 copies 2544h and 80F3h: triggers and domain clock on.
// - With gating bypassed no gating trigger is issued and no ack awaited.
// - Completion of sequence B triggers the peripheral gating controller.
// - Divide copy delays next copy 64 cycles; selected level must hold.
`timescale 1ns/1ps
`default_nettype none
`include "pss_consts.vh"
module pss_sequencer (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [1:0] main_level,
   input wire [1:0] d1_level,
   input wire [3:0] wakeup_event,
   input wire gating_ack,
   output reg gating_trigger,
   output reg [15:0] active_step_value,
   output reg [15:0] active_main_cfg,
   output reg [15:0] active_d1_cfg
);
   localparam S_IDLE = 3'd0;
   localparam S_FETCH = 3'd1;
   localparam S_WAIT = 3'd2;
   localparam S_ACK = 3'd3;

   reg [15:0] step_mem [0:`PSS_STEP_WORDS-1];
   reg [2:0] state;
   reg [2:0] step;
   reg seq_b;
   reg en_a;
   reg en_b;
   reg [3:0] wake_en;
   reg bypass;
   reg main_en_d;
   reg d1_en_d;
   reg [3:0] lvl_s1;
   reg [3:0] lvl_s2;
   reg [3:0] lvl_s3;
   reg [3:0] lvl_stable;
   reg [3:0] lvl_flag;
   reg [3:0] wk_s1;
   reg [3:0] wk_s2;
   reg [3:0] wk_s3;
   reg [3:0] wk_stable;
   reg [3:0] wk_prev;
   reg ack_s1;
   reg ack_s2;
   reg ack_s3;
   reg ack_stable;
   reg [3:0] cond_sel;
   reg [31:0] next_rdata;
   reg next_err;
   reg div_start;
   integer i;

   wire access = psel && penable && !pready;
   wire wr_done = psel && penable && pready && pwrite && !pslverr;
   wire in_mem = ({paddr[11:8], 8'h00} == `PSS_OFF_STEP_BASE) &&
      (paddr[1:0] == 2'b00);
   wire [5:0] mem_idx = paddr[7:2];
   wire mem_ok = in_mem && (mem_idx < 6'd36);
   wire [5:0] base = seq_b ? 6'd18 : 6'd0;
   wire [5:0] sidx = base + {3'b000, step};
   wire [15:0] cur_step = step_mem[sidx];
   wire [15:0] cur_main = step_mem[sidx + 6'd6];
   wire [15:0] cur_d1 = step_mem[sidx + 6'd12];
   wire div_done;
   wire cond_ok = &(~cond_sel | lvl_flag);
   wire [3:0] wake_hit = wk_stable & ~wk_prev & wake_en;
   wire finish = (state == S_FETCH && step == 3'd5 &&
      cur_step == `PSS_STEP_DISABLED) ||
      (state == S_WAIT && step == 3'd5 && div_done && cond_ok);
   wire set_a = wr_done && paddr == `PSS_OFF_CONTROL &&
      pwdata[`PSS_CTL_TRIG_A];
   wire set_b = (wr_done && paddr == `PSS_OFF_CONTROL &&
      pwdata[`PSS_CTL_TRIG_B]) || (|wake_hit);

   pss_delay u_delay (
      .pclk(pclk),
      .presetn(presetn),
      .start(div_start),
      .done(div_done)
   );

   // Pin inputs pass three flops; a value counts once stages two and three agree.
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_sync
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               lvl_s1[g] <= 1'b0;
               lvl_s2[g] <= 1'b0;
               lvl_s3[g] <= 1'b0;
               lvl_stable[g] <= 1'b0;
               wk_s1[g] <= 1'b0;
               wk_s2[g] <= 1'b0;
               wk_s3[g] <= 1'b0;
               wk_stable[g] <= 1'b0;
               wk_prev[g] <= 1'b0;
            end else begin
               lvl_s1[g] <= (g < 2) ? main_level[g % 2] : d1_level[g % 2];
               lvl_s2[g] <= lvl_s1[g];
               lvl_s3[g] <= lvl_s2[g];
               if (lvl_s2[g] == lvl_s3[g]) begin
                  lvl_stable[g] <= lvl_s3[g];
               end
               wk_s1[g] <= wakeup_event[g];
               wk_s2[g] <= wk_s1[g];
               wk_s3[g] <= wk_s2[g];
               if (wk_s2[g] == wk_s3[g]) begin
                  wk_stable[g] <= wk_s3[g];
               end
               wk_prev[g] <= wk_stable[g];
            end
         end
      end
   endgenerate

   // Level flags read zero while a comparator is off or was just enabled.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_en_d <= 1'b0;
         d1_en_d <= 1'b0;
         lvl_flag <= 4'h0;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
         ack_s3 <= 1'b0;
         ack_stable <= 1'b0;
      end else begin
         main_en_d <= active_main_cfg[`PSS_CFG_CMP_EN_BIT];
         d1_en_d <= active_d1_cfg[`PSS_CFG_CMP_EN_BIT];
         lvl_flag[1:0] <= lvl_stable[1:0] &
            {2{main_en_d && active_main_cfg[`PSS_CFG_CMP_EN_BIT]}};
         lvl_flag[3:2] <= lvl_stable[3:2] &
            {2{d1_en_d && active_d1_cfg[`PSS_CFG_CMP_EN_BIT]}};
         ack_s1 <= gating_ack;
         ack_s2 <= ack_s1;
         ack_s3 <= ack_s2;
         if (ack_s2 == ack_s3) begin
            ack_stable <= ack_s3;
         end
      end
   end

   // Sequence engine: one copy per enabled step, steps one to six in order.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= S_IDLE;
         step <= 3'd0;
         seq_b <= 1'b0;
         en_a <= 1'b0;
         en_b <= 1'b0;
         cond_sel <= `PSS_SEL_NONE;
         div_start <= 1'b0;
         gating_trigger <= 1'b0;
         active_step_value <= 16'h0000;
         active_main_cfg <= 16'h0000;
         active_d1_cfg <= 16'h0000;
      end else begin
         div_start <= 1'b0;
         gating_trigger <= 1'b0;
         // A trigger in the cycle of completion wins over the clear.
         en_a <= set_a || (en_a && !(finish && !seq_b));
         en_b <= set_b || (en_b && !(finish && seq_b));
         case (state)
            S_IDLE: begin
               step <= 3'd0;
               if (en_a || en_b) begin
                  seq_b <= !en_a;
                  state <= S_FETCH;
               end
            end
            S_FETCH: begin
               if (cur_step != `PSS_STEP_DISABLED) begin
                  active_step_value <= cur_step;
                  active_main_cfg <= cur_main;
                  active_d1_cfg <= cur_d1;
                  cond_sel <= cur_step[`PSS_STEP_SEL_MSB:`PSS_STEP_SEL_LSB];
                  div_start <= cur_step[`PSS_STEP_DIV_BIT];
                  state <= S_WAIT;
               end else if (step == 3'd5) begin
                  state <= (seq_b && !bypass) ? S_ACK : S_IDLE;
                  gating_trigger <= seq_b && !bypass;
               end else begin
                  step <= step + 3'd1;
               end
            end
            S_WAIT: begin
               if (div_done && cond_ok) begin
                  cond_sel <= `PSS_SEL_NONE;
                  if (step == 3'd5) begin
                     state <= (seq_b && !bypass) ? S_ACK : S_IDLE;
                     gating_trigger <= seq_b && !bypass;
                  end else begin
                     step <= step + 3'd1;
                     state <= S_FETCH;
                  end
               end
            end
            S_ACK: begin
               if (ack_stable) begin
                  state <= S_IDLE;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // Read mux and error answer for the APB slave.
   always @* begin
      next_rdata = 32'h00000000;
      next_err = 1'b0;
      if (mem_ok) begin
         next_rdata = {16'h0000, step_mem[mem_idx]};
      end else begin
         case (paddr)
            `PSS_OFF_CONTROL: next_rdata = {23'h000000, bypass, wake_en,
               en_b, en_a, 2'b00};
            `PSS_OFF_STATUS: next_rdata = {20'h00000, 3'b000, ack_stable,
               lvl_flag, 1'b0, state};
            `PSS_OFF_ACT_STEP: next_rdata = {16'h0000, active_step_value};
            `PSS_OFF_ACT_MAIN: next_rdata = {16'h0000, active_main_cfg};
            `PSS_OFF_ACT_D1: next_rdata = {16'h0000, active_d1_cfg};
            default: next_err = 1'b1;
         endcase
      end
   end

   // Every access takes one wait cycle; writes land on the pready edge.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         wake_en <= 4'h0;
         bypass <= 1'b0;
         for (i = 0; i < `PSS_STEP_WORDS; i = i + 1) begin
            step_mem[i] <= 16'h0000;
         end
      end else begin
         pready <= access;
         pslverr <= access && next_err;
         prdata <= (access && !pwrite) ? next_rdata : 32'h00000000;
         if (wr_done && mem_ok) begin
            step_mem[mem_idx] <= pwdata[15:0];
         end
         if (wr_done && paddr == `PSS_OFF_CONTROL) begin
            wake_en <= pwdata[7:4];
            bypass <= pwdata[`PSS_CTL_BYPASS];
         end
      end
   end
endmodule // pss_sequencer
`default_nettype wire
